/* rtl/adc_mode_ctrl.sv */
// mode selection, control register and serial/parallel read-out control
`timescale 1ns/1ps
module adc_mode_ctrl #(
  parameter int RESOLUTION = adc_ctrl_pkg::FULL_RESOLUTION
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // mode pins
  input wire logic iface_select_pin,
  input wire logic config_source_pin,
  input wire logic intref_or_store_pin,
  // conversion control pins
  input wire logic conversion_start_a,
  input wire logic conversion_start_b,
  input wire logic conversion_start_c,
  output logic busy,
  // parallel bus pins
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic data_bus_oe_n,
  // serial link pins
  input wire logic frame_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out_lanes,
  output logic serial_out_oe_n,
  // analog core side
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] conversion_result,
  output logic intref_enable,
  output logic [adc_ctrl_pkg::CR_DAC_WIDTH-1:0] dac_code,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 27;
  // active-low pins rest high, so leaving reset shows no false edge
  localparam logic [NPIN-1:0] PIN_IDLE = 27'h00001c0;
  logic [NPIN-1:0] pin_raw, pin_meta, pin_sync, pin_prev;

  assign pin_raw = {data_bus_in, serial_in, shift_clock, frame_select,
                    read_n, chip_select_n, conversion_start_c,
                    conversion_start_b, conversion_start_a,
                    intref_or_store_pin, config_source_pin,
                    iface_select_pin};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic serial_mode, software_mode, dual_pin;
  logic [2:0] start_now, start_was;
  logic cs_n_s, rd_n_s, fs_now, fs_was, sck_now, sck_was, sdi_s;
  logic [15:0] db_s;
  assign serial_mode = pin_sync[0];
  assign software_mode = pin_sync[1];
  assign dual_pin = pin_sync[2];
  assign start_now = pin_sync[5:3];
  assign start_was = pin_prev[5:3];
  assign cs_n_s = pin_sync[6];
  assign rd_n_s = pin_sync[7];
  assign fs_now = pin_sync[8];
  assign fs_was = pin_prev[8];
  assign sck_now = pin_sync[9];
  assign sck_was = pin_prev[9];
  assign sdi_s = pin_sync[10];
  assign db_s = pin_sync[26:11];

  function automatic logic rose(input logic now, input logic was);
    return now && !was;
  endfunction
  function automatic logic fell(input logic now, input logic was);
    return !now && was;
  endfunction
  // lower resolutions never show a one on bit 15
  function automatic logic [15:0] pad_msb(input logic [15:0] word);
    return {word[15] && RESOLUTION >= adc_ctrl_pkg::FULL_RESOLUTION,
            word[14:0]};
  endfunction

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [adc_ctrl_pkg::DATA_WIDTH-1:0] buf_out_data;

  result_buffer u_result_buffer (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(conversion_result),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adc_ctrl_pkg::conv_state_type conv_state;
  adc_ctrl_pkg::conv_state_type next_conv_state;
  logic [7:0] conv_count;
  logic [7:0] next_conv_count;
  logic [31:0] control_register;
  logic [31:0] next_control_register;
  logic store_half;
  logic next_store_half;
  logic [15:0] tx_shift;
  logic [15:0] next_tx_shift;
  logic [31:0] rx_shift;
  logic [31:0] next_rx_shift;
  logic [5:0] rx_count;
  logic [5:0] next_rx_count;
  logic next_busy;
  logic [15:0] next_data_bus_out;
  logic next_data_bus_oe_n;
  logic next_serial_out;
  logic next_serial_out_oe_n;
  logic next_intref_enable;
  logic [adc_ctrl_pkg::CR_DAC_WIDTH-1:0] next_dac_code;
  logic [31:0] next_reg_rdata;
  logic pop;

  assign buf_out_ready = pop;

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_conv_state = conv_state;
    next_conv_count = conv_count;
    next_busy = busy;
    buf_in_valid = 1'b0;
    case (conv_state)
      adc_ctrl_pkg::CONV_IDLE: begin
        if ((start_now & ~start_was) != 3'h0) begin
          next_conv_state = adc_ctrl_pkg::CONV_RUN;
          next_conv_count = adc_ctrl_pkg::CONV_CYCLES;
          next_busy = 1'b1;
        end
      end
      adc_ctrl_pkg::CONV_RUN: begin
        next_conv_count = conv_count - 8'h01;
        if (conv_count == 8'h01) begin
          next_conv_state = adc_ctrl_pkg::CONV_DELIVER;
        end
      end
      adc_ctrl_pkg::CONV_DELIVER: begin
        // busy holds while the buffer is full, so no result is lost
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          next_conv_state = adc_ctrl_pkg::CONV_IDLE;
          next_busy = 1'b0;
        end
      end
      default: begin
        next_conv_state = adc_ctrl_pkg::CONV_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // control register, read-out and settings
  // ----------------------------------------------------------------
  always_comb begin
    next_control_register = control_register;
    next_store_half = store_half;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_rx_count = rx_count;
    next_data_bus_out = data_bus_out;
    next_data_bus_oe_n = 1'b1;
    next_serial_out = serial_out_lanes;
    next_serial_out_oe_n = 1'b1;
    next_reg_rdata = 32'h0000_0000;
    pop = 1'b0;

    // register port write; the link paths below take priority
    if (reg_wr && reg_addr == adc_ctrl_pkg::CTRL_OFFSET) begin
      next_control_register = reg_wdata;
    end

    if (!serial_mode) begin
      // parallel read: take a word on the read falling edge
      if (!cs_n_s && fell(rd_n_s, pin_prev[7])) begin
        pop = buf_out_valid;
        next_data_bus_out = pad_msb(buf_out_valid ? buf_out_data : 16'h0000);
      end
      next_data_bus_oe_n = cs_n_s || rd_n_s;
      // store at the strobe's rising edge, high half first, then low
      if (software_mode && !cs_n_s && rose(dual_pin, pin_prev[2])) begin
        next_store_half = ~store_half;
        if (!store_half) begin
          next_control_register[31:16] = db_s;
        end else begin
          next_control_register[15:0] = db_s;
        end
      end
      if (cs_n_s) begin
        next_store_half = 1'b0;
      end
    end else begin
      if (fell(fs_now, fs_was)) begin
        // frame opens: first bit shows before any clock edge
        pop = buf_out_valid;
        next_tx_shift = pad_msb(buf_out_valid ? buf_out_data : 16'h0000);
        next_serial_out = next_tx_shift[15];
        next_rx_count = 6'h00;
      end else if (!fs_now && rose(sck_now, sck_was)) begin
        next_tx_shift = {tx_shift[14:0], 1'b0};
        next_serial_out = tx_shift[14];
      end
      if (!fs_now && fell(sck_now, sck_was)) begin
        next_rx_shift = {rx_shift[30:0], sdi_s};
        next_rx_count = rx_count + 6'h01;
        if (rx_count + 6'h01 == adc_ctrl_pkg::CR_SERIAL_BITS) begin
          next_rx_count = 6'h00;
          if (software_mode) begin
            next_control_register = {rx_shift[30:0], sdi_s};
          end
        end
      end
      // output enable follows the synchronised frame select
      next_serial_out_oe_n = fs_now;
    end

    // settings source
    if (software_mode) begin
      next_intref_enable = control_register[adc_ctrl_pkg::CR_INTREF_BIT];
    end else begin
      next_intref_enable = dual_pin;
    end
    next_dac_code = control_register[adc_ctrl_pkg::CR_DAC_LSB +:
                                     adc_ctrl_pkg::CR_DAC_WIDTH];

    // register port read, answered one cycle later
    if (reg_rd) begin
      case (reg_addr)
        adc_ctrl_pkg::CTRL_OFFSET: begin
          next_reg_rdata = control_register;
        end
        adc_ctrl_pkg::STATUS_OFFSET: begin
          next_reg_rdata[adc_ctrl_pkg::ST_BUSY_BIT] = busy;
          next_reg_rdata[adc_ctrl_pkg::ST_SERIAL_BIT] = serial_mode;
          next_reg_rdata[adc_ctrl_pkg::ST_SOFTWARE_BIT] = software_mode;
          next_reg_rdata[adc_ctrl_pkg::ST_INTREF_BIT] = intref_enable;
          next_reg_rdata[adc_ctrl_pkg::ST_DATA_READY_BIT] = buf_out_valid;
          next_reg_rdata[adc_ctrl_pkg::ST_DAC_LSB +:
                         adc_ctrl_pkg::CR_DAC_WIDTH] = dac_code;
        end
        default: begin
          next_reg_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_state <= adc_ctrl_pkg::CONV_IDLE;
      conv_count <= 8'h00;
      busy <= 1'b0;
      control_register <= adc_ctrl_pkg::CR_RESET;
      store_half <= 1'b0;
      tx_shift <= 16'h0000;
      rx_shift <= 32'h0000_0000;
      rx_count <= 6'h00;
      data_bus_out <= 16'h0000;
      data_bus_oe_n <= 1'b1;
      serial_out_lanes <= 1'b0;
      serial_out_oe_n <= 1'b1;
      intref_enable <= 1'b0;
      dac_code <= '0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      conv_state <= next_conv_state;
      conv_count <= next_conv_count;
      busy <= next_busy;
      control_register <= next_control_register;
      store_half <= next_store_half;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      rx_count <= next_rx_count;
      data_bus_out <= next_data_bus_out;
      data_bus_oe_n <= next_data_bus_oe_n;
      serial_out_lanes <= next_serial_out;
      serial_out_oe_n <= next_serial_out_oe_n;
      intref_enable <= next_intref_enable;
      dac_code <= next_dac_code;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

/* rtl/adc_ctrl_pkg.sv */
// constants shared by the converter mode and serial frame control
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 1260;
  // longest conversion, rounded up so busy never drops early
  localparam int CONV_CYCLES_INT =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_CYCLES = CONV_CYCLES_INT[7:0];

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // ----------------------------------------------------------------
  // control register layout and reset value
  // ----------------------------------------------------------------
  localparam int CR_WIDTH = 32;
  localparam int CR_INTREF_BIT = 25;
  localparam int CR_DAC_LSB = 0;
  localparam int CR_DAC_WIDTH = 10;
  localparam logic [31:0] CR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SERIAL_BIT = 1;
  localparam int ST_SOFTWARE_BIT = 2;
  localparam int ST_INTREF_BIT = 3;
  localparam int ST_DATA_READY_BIT = 4;
  localparam int ST_DAC_LSB = 16;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int DATA_WIDTH = 16;
  localparam int FULL_RESOLUTION = 16;
  localparam logic [5:0] CR_SERIAL_BITS = 6'h20;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_DELIVER
  } conv_state_type;

endpackage

/* rtl/result_buffer.sv */
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
module result_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [adc_ctrl_pkg::DATA_WIDTH-1:0] out_data
);

  logic [adc_ctrl_pkg::DATA_WIDTH-1:0] store [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

endmodule

/* verif/adc_mode_ctrl_sva.sv */
// bound assertions for the converter mode and frame control
`timescale 1ns/1ps
module adc_mode_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins
  input wire logic iface_select_pin,
  input wire logic config_source_pin,
  input wire logic intref_or_store_pin,
  input wire logic conversion_start_a,
  input wire logic busy,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic data_bus_oe_n,
  input wire logic frame_select,
  input wire logic shift_clock,
  input wire logic serial_out_lanes,
  input wire logic serial_out_oe_n,
  // core side and register port
  input wire logic intref_enable,
  input wire logic [adc_ctrl_pkg::CR_DAC_WIDTH-1:0] dac_code,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [9:0] busy_len;
  logic [9:0] next_busy_len;
  logic [3:0] sclk_age;
  logic [3:0] next_sclk_age;
  logic sclk_prev;
  logic [9:0] last_dac;
  logic [9:0] next_last_dac;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // saturating, so a long stall on a full buffer cannot wrap
  always_comb begin
    next_busy_len = 10'h0;
    if (busy) begin
      next_busy_len = (busy_len == 10'h3ff) ? busy_len : busy_len + 10'h1;
    end
    next_sclk_age = (sclk_age == 4'hf) ? sclk_age : sclk_age + 4'h1;
    if (shift_clock && !sclk_prev) begin
      next_sclk_age = 4'h0;
    end
    next_last_dac = last_dac;
    if (reg_wr && reg_addr == adc_ctrl_pkg::CTRL_OFFSET) begin
      next_last_dac = reg_wdata[9:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_len <= 10'h0;
      sclk_age <= 4'hf;
      sclk_prev <= 1'b0;
      last_dac <= 10'h0;
    end else begin
      busy_len <= next_busy_len;
      sclk_age <= next_sclk_age;
      sclk_prev <= shift_clock;
      last_dac <= next_last_dac;
    end
  end
  sequence s_idle_start;
    !busy ##1 ($rose(conversion_start_a) && !busy);
  endsequence
  sequence s_ctrl_write;
    reg_wr && reg_addr == adc_ctrl_pkg::CTRL_OFFSET;
  endsequence
  a_busy_rise: assert property (s_idle_start |-> ##[1:5] busy)
    else $error("busy missing after start");
  a_busy_long: assert property (
    $fell(busy) |-> busy_len >= {2'h0, adc_ctrl_pkg::CONV_CYCLES})
    else $error("busy dropped early");
  a_ref_hw_on: assert property (
    (!config_source_pin && intref_or_store_pin)[*6] |-> intref_enable)
    else $error("reference off in hardware mode");
  a_ref_hw_off: assert property (
    (!config_source_pin && !intref_or_store_pin)[*6] |-> !intref_enable)
    else $error("reference on in hardware mode");
  a_ser_release: assert property (frame_select[*7] |-> serial_out_oe_n)
    else $error("serial output driven outside frame");
  a_ser_drive: assert property (
    (iface_select_pin && !frame_select)[*6] |-> !serial_out_oe_n)
    else $error("serial output not driven in frame");
  a_par_drive: assert property (
    (!iface_select_pin && !chip_select_n && !read_n)[*6] |-> !data_bus_oe_n)
    else $error("parallel bus not driven on read");
  a_bit_step: assert property (
    !serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out_lanes)
    |-> sclk_age <= 4'h6)
    else $error("serial bit changed without clock rise");
  a_rdata_idle: assert property (
    $past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_dac_load: assert property (s_ctrl_write |-> ##[1:3] dac_code == last_dac)
    else $error("dac code not loaded");
endmodule

bind adc_mode_ctrl adc_mode_ctrl_sva u_adc_mode_ctrl_sva (.clk(clk),
  .sys_rst(sys_rst), .iface_select_pin(iface_select_pin),
  .config_source_pin(config_source_pin),
  .intref_or_store_pin(intref_or_store_pin),
  .conversion_start_a(conversion_start_a), .busy(busy),
  .chip_select_n(chip_select_n), .read_n(read_n),
  .data_bus_oe_n(data_bus_oe_n), .frame_select(frame_select),
  .shift_clock(shift_clock), .serial_out_lanes(serial_out_lanes),
  .serial_out_oe_n(serial_out_oe_n), .intref_enable(intref_enable),
  .dac_code(dac_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* verif/host_serial_model.sv */
// host side of the serial link: frame select, shift clock, data in
`timescale 1ns/1ps
module host_serial_model (
  // clock
  input wire logic clk,
  // serial link
  output logic frame_select,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out_lanes,
  input wire logic serial_out_oe_n,
  // converter status
  input wire logic busy
);
  logic in_frame;
  initial begin
    frame_select = 1'b1;
    shift_clock = 1'b0;
    serial_in = 1'b0;
    in_frame = 1'b0;
  end
  // idle data line toggles so a stale level never passes for data
  always @(posedge clk) begin
    if (!in_frame) begin
      serial_in <= ~serial_in;
    end
  end
  // shift clock stands low between frames; 80 ns period inside
  task automatic frame(input logic [31:0] din, output logic [15:0] dout);
    int i;
    dout = 16'h0;
    for (i = 0; i < 400 && busy !== 1'b0; i++) begin
      @(posedge clk);
    end
    in_frame <= 1'b1;
    frame_select <= 1'b0;
    for (i = 31; i >= 0; i--) begin
      repeat (5) @(posedge clk);
      serial_in <= din[i];
      shift_clock <= 1'b1;
      if (i > 15) begin
        // a released lane reads as the inverse of its last bit
        dout[i-16] = serial_out_oe_n ? ~serial_out_lanes : serial_out_lanes;
      end
      repeat (5) @(posedge clk);
      shift_clock <= 1'b0;
    end
    repeat (5) @(posedge clk);
    frame_select <= 1'b1;
    in_frame <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the converter mode and frame control
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic iface_select_pin = 1'b0;
  logic config_source_pin = 1'b0;
  logic intref_or_store_pin = 1'b1;
  logic [2:0] start = 3'h0;
  logic chip_select_n = 1'b1;
  logic read_n = 1'b1;
  logic [15:0] data_bus_in = 16'h0;
  logic [15:0] result = 16'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] data_bus_out;
  logic busy, data_bus_oe_n, frame_select, shift_clock, serial_in;
  logic serial_out_lanes, serial_out_oe_n, intref_enable;
  logic [9:0] dac_code;
  logic [31:0] seed = 32'h3f;
  logic [15:0] exp_w [3];
  logic [15:0] narrow_out, narrow_w;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  adc_mode_ctrl u_adc_mode_ctrl (.clk(clk), .sys_rst(sys_rst),
    .iface_select_pin(iface_select_pin),
    .config_source_pin(config_source_pin),
    .intref_or_store_pin(intref_or_store_pin),
    .conversion_start_a(start[0]), .conversion_start_b(start[1]),
    .conversion_start_c(start[2]), .busy(busy),
    .chip_select_n(chip_select_n), .read_n(read_n),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .frame_select(frame_select),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out_lanes(serial_out_lanes), .serial_out_oe_n(serial_out_oe_n),
    .conversion_result(result), .intref_enable(intref_enable),
    .dac_code(dac_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  host_serial_model u_host_serial_model (.clk(clk),
    .frame_select(frame_select), .shift_clock(shift_clock),
    .serial_in(serial_in), .serial_out_lanes(serial_out_lanes),
    .serial_out_oe_n(serial_out_oe_n), .busy(busy));
  // 14-bit variant on the same pins, watched for its bit 15
  adc_mode_ctrl #(.RESOLUTION(14)) u_adc_mode_ctrl_narrow (.clk(clk),
    .sys_rst(sys_rst), .iface_select_pin(iface_select_pin),
    .config_source_pin(config_source_pin),
    .intref_or_store_pin(intref_or_store_pin),
    .conversion_start_a(start[0]), .conversion_start_b(start[1]),
    .conversion_start_c(start[2]), .busy(),
    .chip_select_n(chip_select_n), .read_n(read_n),
    .data_bus_in(data_bus_in), .data_bus_out(narrow_out),
    .data_bus_oe_n(), .frame_select(frame_select),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out_lanes(), .serial_out_oe_n(),
    .conversion_result(result), .intref_enable(), .dac_code(),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata());
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic test_done;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic par_read(output logic [15:0] d);
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
    repeat (6) @(posedge clk);
    d = data_bus_out;
    narrow_w = narrow_out;
    check({31'h0, data_bus_oe_n}, 32'h0);
    read_n <= 1'b1;
    chip_select_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // upper half first; both halves inside one chip-select window
  task automatic par_store(input logic [31:0] d);
    int i;
    chip_select_n <= 1'b0;
    for (i = 1; i >= 0; i--) begin
      data_bus_in <= d[16*i +: 16];
      intref_or_store_pin <= 1'b0;
      repeat (4) @(posedge clk);
      intref_or_store_pin <= 1'b1;
      repeat (4) @(posedge clk);
    end
    chip_select_n <= 1'b1;
    data_bus_in <= ~d[15:0];
    repeat (4) @(posedge clk);
  endtask
  task automatic convert(input int k, input logic [15:0] r);
    result <= r;
    start[k] <= 1'b1;
    repeat (5) @(posedge clk);
    start[k] <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 400 && busy !== 1'b0; n++) begin
      @(posedge clk);
    end
    check({31'h0, busy}, 32'h0);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done;
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    int i;
    logic [31:0] v;
    logic [31:0] rd;
    logic [15:0] w;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    reg_read(adc_ctrl_pkg::CTRL_OFFSET, rd);
    check(rd, adc_ctrl_pkg::CR_RESET);
    reg_read(8'h08, rd);
    check(rd, 32'h0);
    for (i = 0; i < 2; i++) begin
      intref_or_store_pin <= i[0];
      repeat (8) @(posedge clk);
      check({31'h0, intref_enable}, 32'(i));
    end
    reg_read(adc_ctrl_pkg::STATUS_OFFSET, rd);
    check(rd, 32'h1 << adc_ctrl_pkg::ST_INTREF_BIT);
    par_store(32'h0000_03ff);
    reg_read(adc_ctrl_pkg::CTRL_OFFSET, rd);
    check(rd, adc_ctrl_pkg::CR_RESET);
    config_source_pin <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 32'h0200_03ff : seed;
      reg_write(adc_ctrl_pkg::CTRL_OFFSET, v);
      reg_read(adc_ctrl_pkg::CTRL_OFFSET, rd);
      check(rd, v);
      intref_or_store_pin <= ~v[25];
      repeat (6) @(posedge clk);
      check({31'h0, intref_enable}, {31'h0, v[25]});
      check({22'h0, dac_code}, {22'h0, v[9:0]});
    end
    intref_or_store_pin <= 1'b1;
    seed = xs(seed);
    v = seed;
    par_store(v);
    reg_read(adc_ctrl_pkg::CTRL_OFFSET, rd);
    check(rd, v);
    // third word stalls until the two-entry buffer has room
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      exp_w[i] = (i == 0) ? 16'h8001 : seed[15:0];
      convert(i, exp_w[i]);
      check({31'h0, busy}, 32'h1);
      if (i < 2) begin
        wait_idle;
      end
      repeat (5) @(posedge clk);
    end
    repeat (250) @(posedge clk);
    check({31'h0, busy}, 32'h1);
    for (i = 0; i < 3; i++) begin
      par_read(w);
      check({16'h0, w}, {16'h0, exp_w[i]});
      check({16'h0, narrow_w}, {17'h0, exp_w[i][14:0]});
    end
    iface_select_pin <= 1'b1;
    repeat (6) @(posedge clk);
    for (i = 0; i < 2; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 32'haaaa_5555 : seed;
      convert(i + 1, seed[31:16]);
      wait_idle;
      u_host_serial_model.frame(v, w);
      check({16'h0, w}, {16'h0, seed[31:16]});
      reg_read(adc_ctrl_pkg::CTRL_OFFSET, rd);
      check(rd, v);
      repeat (5) @(posedge clk);
    end
    test_done;
  end
endmodule
